// ### design/enc_cfg.svh
// register map, field positions and timing constants of the encoder block
`ifndef ENC_CFG_SVH
`define ENC_CFG_SVH
`define REG_CTRL 4'h0
`define REG_INSEL 4'h1
`define REG_POS 4'h2
`define REG_CMD 4'h3
`define REG_DEB0 4'h4
`define REG_MULT 4'h7
`define REG_DIV 4'h8
`define REG_MBND 4'h9
`define REG_DBND 4'hA
`define REG_STAT 4'hB
`define CTRL_REV 0
`define CTRL_DIR 1
`define CTRL_TERM 2
`define CTRL_VAL 3
`define CTRL_RSEL 5:4
`define CTRL_MSRC 7:6
`define INSEL_A 1:0
`define INSEL_B 3:2
`define CMD_CLR 0
`define MULT_MIN 8'h01
`define MULT_MAX 8'hFF
`define DIV_MIN 8'h01
`define DIV_MAX 8'hFF
`define CLK_PERIOD_NS 8
`define DEB_STEP_NS 1000
`define HYST_STEPS 32'h0000_0002
`endif

// ### design/enc_pkg.sv
// types shared by the encoder block
package enc_pkg;
  typedef enum logic {
    DIR_FWD = 1'b0,
    DIR_REV = 1'b1
  } dir_t;
  typedef logic [1:0] port_sel_t;
  typedef logic [7:0] factor_t;
endpackage

// ### design/encoder_tick_and_rate_multiplier.sv
// quadrature encoder with tick generation, position counter and rate multiplier
`timescale 1ns/1ps
`default_nettype none
`include "enc_cfg.svh"
module encoder_tick_and_rate_multiplier #(
  parameter int PER_W = 24
) (
  input wire logic i_sys_clk, // system clock, 125 MHz
  input wire logic i_reset_n, // asynchronous reset, active low
  input wire logic [3:0] i_avs_address, // register word index
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall while high
  input wire logic [2:1] i_port_in, // input ports 1 and 2
  input wire logic i_bidirectional_port_in, // port 0 receiver level
  output logic o_bidirectional_port_out, // port 0 drive level
  output logic o_bidirectional_port_oe, // port 0 driven when high
  output logic o_bidirectional_port_term, // port 0 termination enable
  output logic o_tick, // encoder tick pulse
  output logic o_mult_pulse, // multiplier output pulse
  output logic o_target_clear // trigger target clear pulse
);
  import enc_pkg::*;

  localparam int US_CYCLES = `DEB_STEP_NS / `CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q;
  logic [3:0] insel_q;
  logic [15:0] deb_time_q [3];
  factor_t mult_q;
  factor_t div_q;
  logic wait_q;
  logic wr_fire;
  logic [2:0] lvl_q;
  logic [31:0] pos_q;
  dir_t dir_q;
  logic clr;

  function automatic logic port_pick(input port_sel_t sel, input logic [2:0] lv);
    port_pick = (sel > 2'h2) ? 1'b0 : lv[sel];
  endfunction

  function automatic factor_t clamp(input factor_t v, input factor_t lo,
                                    input factor_t hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign wr_fire = i_avs_write && !wait_q;

  // one wait cycle per request; write lands on the edge waitrequest is low
  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      wait_q <= 1'b1;
    else
      wait_q <= !((i_avs_read || i_avs_write) && wait_q);
  end

  //////////////////////////////////////////////////////////////////////////////
  // input at reset
  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= 8'h00;
      insel_q <= 4'h0;
      mult_q <= `MULT_MIN;
      div_q <= `DIV_MIN;
      for (int i = 0; i < 3; i++)
        deb_time_q[i] <= 16'h0000;
    end
    else if (wr_fire)
    begin
      if (i_avs_address == `REG_CTRL)
        ctrl_q <= i_avs_writedata[7:0];
      if (i_avs_address == `REG_INSEL)
        insel_q <= i_avs_writedata[3:0];
      if (i_avs_address == `REG_MULT)
        mult_q <= clamp(i_avs_writedata[7:0], `MULT_MIN, `MULT_MAX);
      if (i_avs_address == `REG_DIV)
        div_q <= clamp(i_avs_writedata[7:0], `DIV_MIN, `DIV_MAX);
      for (int i = 0; i < 3; i++)
        if (i_avs_address == `REG_DEB0 + 4'(i))
          deb_time_q[i] <= i_avs_writedata[15:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_bidirectional_port_oe <= 1'b0;
      o_bidirectional_port_out <= 1'b0;
      o_bidirectional_port_term <= 1'b0;
    end
    else
    begin
      o_bidirectional_port_oe <= ctrl_q[`CTRL_DIR];
      o_bidirectional_port_out <= ctrl_q[`CTRL_VAL];
      o_bidirectional_port_term <= ctrl_q[`CTRL_TERM] && !ctrl_q[`CTRL_DIR];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && wait_q)
    begin
      o_avs_readdata <= 32'h0000_0000;
      case (i_avs_address)
        `REG_CTRL: o_avs_readdata[7:0] <= ctrl_q;
        `REG_INSEL: o_avs_readdata[3:0] <= insel_q;
        `REG_POS: o_avs_readdata <= pos_q;
        `REG_MULT: o_avs_readdata[7:0] <= mult_q;
        `REG_DIV: o_avs_readdata[7:0] <= div_q;
        `REG_MBND: o_avs_readdata[23:0] <= {`MULT_MAX, 8'h00, `MULT_MIN};
        `REG_DBND: o_avs_readdata[23:0] <= {`DIV_MAX, 8'h00, `DIV_MIN};
        `REG_STAT: o_avs_readdata[3:0] <= {dir_q, lvl_q};
        default:
        begin
          for (int i = 0; i < 3; i++)
            if (i_avs_address == `REG_DEB0 + 4'(i))
              o_avs_readdata[15:0] <= deb_time_q[i];
        end
      endcase
    end
  end
  assign o_avs_waitrequest = wait_q;

  //////////////////////////////////////////////////////////////////////////////
  logic [6:0] us_cnt_q;
  logic us_tick_q;
  logic [2:0] raw;
  logic [15:0] deb_cnt_q [3];
  assign raw = {i_port_in, i_bidirectional_port_in};

  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      us_cnt_q <= 7'h00;
      us_tick_q <= 1'b0;
    end
    else
    begin
      us_tick_q <= (us_cnt_q == 7'(US_CYCLES - 1));
      us_cnt_q <= (us_cnt_q == 7'(US_CYCLES - 1)) ? 7'h00 : us_cnt_q + 7'h01;
    end
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_deb
    always_ff @(posedge i_sys_clk or negedge rst_n_q)
    begin
      if (!rst_n_q)
      begin
        lvl_q[g] <= 1'b0;
        deb_cnt_q[g] <= 16'h0000;
      end
      else if (deb_time_q[g] == 16'h0000)
      begin
        lvl_q[g] <= raw[g];
        deb_cnt_q[g] <= 16'h0000;
      end
      else if (raw[g] == lvl_q[g])
        deb_cnt_q[g] <= 16'h0000;
      else if (us_tick_q)
      begin
        // first tick may come at once: one extra tick keeps the full stable time
        if (deb_cnt_q[g] >= deb_time_q[g])
        begin
          lvl_q[g] <= raw[g];
          deb_cnt_q[g] <= 16'h0000;
        end
        else
          deb_cnt_q[g] <= deb_cnt_q[g] + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic a_in;
  logic b_in;
  logic [1:0] ab_q;
  logic step_up;
  logic step_dn;
  logic [31:0] pos_d;
  logic [31:0] ext_q;
  logic [31:0] delta;
  logic rst_src_q;
  logic rst_src;
  logic rev_en;

  assign a_in = port_pick(insel_q[`INSEL_A], lvl_q);
  assign b_in = port_pick(insel_q[`INSEL_B], lvl_q);
  assign rst_src = (ctrl_q[`CTRL_RSEL] != 2'h0) &&
                   port_pick(ctrl_q[`CTRL_RSEL] - 2'h1, lvl_q);
  assign rev_en = ctrl_q[`CTRL_REV];
  assign clr = (wr_fire && i_avs_address == `REG_CMD && i_avs_writedata[`CMD_CLR]) ||
               (rst_src && !rst_src_q);

  // four edges per cycle, a leads b forward
  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case ({ab_q, a_in, b_in})
      4'h2, 4'hB, 4'hD, 4'h4: step_up = 1'b1;
      4'h1, 4'h7, 4'hE, 4'h8: step_dn = 1'b1;
      default: ;
    endcase
  end
  assign pos_d = step_up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
  assign delta = pos_d - ext_q;

  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ab_q <= 2'h0;
      rst_src_q <= 1'b0;
      o_target_clear <= 1'b0;
    end
    else
    begin
      ab_q <= {a_in, b_in};
      rst_src_q <= rst_src;
      o_target_clear <= clr;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pos_q <= 32'h0000_0000;
      ext_q <= 32'h0000_0000;
      dir_q <= DIR_FWD;
      o_tick <= 1'b0;
    end
    else if (clr)
    begin
      pos_q <= 32'h0000_0000;
      ext_q <= 32'h0000_0000;
      dir_q <= DIR_FWD;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (step_up || step_dn)
      begin
        pos_q <= pos_d;
        unique case (dir_q)
          DIR_FWD:
          begin
            // ticks past the farthest point, or when rev_en is set and it has gone HYST_STEPS back
            if (!delta[31] && delta != 32'h0000_0000)
            begin
              o_tick <= 1'b1;
              ext_q <= pos_d;
            end
            else if (rev_en && (32'h0000_0000 - delta) >= `HYST_STEPS)
            begin
              o_tick <= 1'b1;
              ext_q <= pos_d;
              dir_q <= DIR_REV;
            end
          end
          DIR_REV:
          begin
            if (!rev_en)
            begin
              dir_q <= DIR_FWD;
              ext_q <= pos_d;
            end
            else if (delta[31])
            begin
              o_tick <= 1'b1;
              ext_q <= pos_d;
            end
            else if (delta >= `HYST_STEPS)
            begin
              o_tick <= 1'b1;
              ext_q <= pos_d;
              dir_q <= DIR_FWD;
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic msrc;
  logic msrc_q;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] period_q;
  logic [PER_W+7:0] limit;
  logic [PER_W+8:0] acc_q;
  logic [PER_W+8:0] acc_n;

  assign msrc = (ctrl_q[`CTRL_MSRC] == 2'h3) ? o_tick :
                port_pick(ctrl_q[`CTRL_MSRC], lvl_q);
  assign limit = period_q * div_q;
  assign acc_n = acc_q + (PER_W+9)'(mult_q);

  // slow inputs saturate the period counter at all ones and stop output
  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      msrc_q <= 1'b0;
      per_cnt_q <= '0;
      period_q <= '0;
    end
    else
    begin
      msrc_q <= msrc;
      if (msrc && !msrc_q)
      begin
        period_q <= per_cnt_q + PER_W'(1);
        per_cnt_q <= '0;
      end
      else if (&per_cnt_q)
        period_q <= '0;
      else
        per_cnt_q <= per_cnt_q + PER_W'(1);
    end
  end

  // accumulator gives period times D over M
  // jitter bounded by one clock period
  always_ff @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      acc_q <= '0;
      o_mult_pulse <= 1'b0;
    end
    else if (period_q == '0)
    begin
      acc_q <= '0;
      o_mult_pulse <= 1'b0;
    end
    else if (acc_n >= (PER_W+9)'(limit))
    begin
      acc_q <= acc_n - (PER_W+9)'(limit);
      o_mult_pulse <= 1'b1;
    end
    else
    begin
      acc_q <= acc_n;
      o_mult_pulse <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n_q);

  a_tick_cause: assert property (o_tick |-> $past(step_up || step_dn))
    else $error("tick without encoder step");
  a_pos_step: assert property (step_up && !clr |=> pos_q == $past(pos_q) + 32'h0000_0001)
    else $error("position did not count up");
  a_fwd_only: assert property (!rev_en && step_dn |=> !o_tick)
    else $error("tick on backward step");
  a_rev_tick: assert property (rev_en && dir_q == DIR_REV && step_dn && delta[31] && !clr
    |=> o_tick)
    else $error("missing reverse tick");
  a_clear_zero: assert property (clr |=> pos_q == 32'h0000_0000 ##0 o_target_clear)
    else $error("clear not applied");
  a_pos_read: assert property (i_avs_read && wait_q && i_avs_address == `REG_POS
    |=> o_avs_readdata == $past(pos_q) && !o_avs_waitrequest)
    else $error("position read wrong");
  a_factor_bound: assert property (mult_q >= `MULT_MIN && div_q >= `DIV_MIN)
    else $error("factor out of bounds");
  a_deb_bypass: assert property (deb_time_q[1] == 16'h0000 ##1 deb_time_q[1] == 16'h0000
    |-> lvl_q[1] == $past(raw[1]))
    else $error("bypass not transparent");
  a_mult_cause: assert property (o_mult_pulse |-> $past(period_q) != '0)
    else $error("pulse without input");
  a_port_input: assert property (!ctrl_q[`CTRL_DIR] |=> !o_bidirectional_port_oe)
    else $error("port driven while input");

  c_tick: cover property (o_tick);
  c_reverse: cover property (dir_q == DIR_REV ##1 o_tick);
  c_mult: cover property (o_mult_pulse ##[1:20] o_mult_pulse);
  c_clear: cover property (o_target_clear);
endmodule // encoder_tick_and_rate_multiplier
`default_nettype wire

// ### test/quad_encoder_model.sv
// quadrature encoder and trigger source model driving the block's input ports
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model #(
  parameter int TRIG_HALF = 32
) (
  input wire logic i_clk, // system clock
  input wire logic i_trig_en, // run the trigger square wave
  output logic o_phase, // phase line
  output logic o_quad, // quadrature line
  output logic o_trig // trigger line
);
  logic [1:0] st = 2'b00;
  logic trig = 1'b0;
  int cnt = 0;
  assign o_phase = st[1];
  assign o_quad = st[0];
  assign o_trig = trig;
  // one step, then a gap so steps never crowd each other
  task automatic step(input logic rev);
    @(posedge i_clk);
    st <= rev ? {st[0], ~st[1]} : {~st[0], st[1]};
    repeat (7) @(posedge i_clk);
  endtask
  always @(posedge i_clk)
  begin
    cnt <= (cnt == TRIG_HALF - 1) ? 0 : cnt + 1;
    if (cnt == TRIG_HALF - 1)
      trig <= i_trig_en & ~trig;
  end
endmodule // quad_encoder_model
`default_nettype wire

// ### test/encoder_tick_and_rate_multiplier_tb_top.sv
// self-checking bench for the encoder tick and rate multiplier block
`timescale 1ns/1ps
`default_nettype none
`include "enc_cfg.svh"
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module encoder_tick_and_rate_multiplier_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic phase, quad, trig, trig_en = 1'b0;
  logic p0_out, p0_oe, p0_term, tick, mpulse, tclr;
  int err_count = 0;
  int check_count = 0;
  int tick_cnt = 0;
  int mult_cnt = 0;
  int clr_cnt = 0;
  int cyc = 0;

  initial
  begin
    forever #4 clk = ~clk;
  end

  encoder_tick_and_rate_multiplier u_dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_port_in({quad, phase}), .i_bidirectional_port_in(trig),
    .o_bidirectional_port_out(p0_out), .o_bidirectional_port_oe(p0_oe),
    .o_bidirectional_port_term(p0_term), .o_tick(tick), .o_mult_pulse(mpulse),
    .o_target_clear(tclr)
  );

  quad_encoder_model u_src (
    .i_clk(clk), .i_trig_en(trig_en), .o_phase(phase), .o_quad(quad), .o_trig(trig)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (tick === 1'b1)
      tick_cnt++;
    if (mpulse === 1'b1)
      mult_cnt++;
    if (tclr === 1'b1)
      clr_cnt++;
    if (cyc == 30000)
    begin
      err_count++;
      final_report();
    end
  end

  // one bus cycle: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    rd_en <= ~w;
    wr_en <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(nm, ex, q)
  endtask

  task automatic expect_enc(input logic [31:0] p, input int t);
    logic [31:0] q;
    bus(1'b0, `REG_POS, 32'h0000_0000, q);
    `CHK("position", p, q)
    `CHK("ticks", t, tick_cnt)
  endtask

  task automatic steps(input logic rev, input int n);
    repeat (n) u_src.step(rev);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  initial
  begin
    logic [31:0] q;
    int m0;
    repeat (10) @(posedge clk);
    `CHK("waitrequest in reset", 1'b1, wreq)
    `CHK("port0 oe in reset", 1'b0, p0_oe)
    `CHK("port0 term in reset", 1'b0, p0_term)
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("ctrl reset", `REG_CTRL, 32'h0000_0000);
    rd_chk("mult bounds", `REG_MBND, 32'h00FF_0001);
    rd_chk("div bounds", `REG_DBND, 32'h00FF_0001);
    rd_chk("unmapped", 4'hF, 32'h0000_0000);
    done("reset");
    wr(`REG_INSEL, 32'h0000_0009);
    steps(1'b0, 8);
    expect_enc(32'h0000_0008, 8);
    steps(1'b1, 3);
    expect_enc(32'h0000_0005, 8);
    steps(1'b0, 3);
    expect_enc(32'h0000_0008, 8);
    steps(1'b0, 1);
    expect_enc(32'h0000_0009, 9);
    done("forward only");
    wr(`REG_CTRL, 32'h0000_0001);
    steps(1'b1, 1);
    steps(1'b0, 1);
    expect_enc(32'h0000_0009, 9);
    steps(1'b1, 4);
    `CHK("reverse ticks", 1'b1, tick_cnt > 9)
    expect_enc(32'h0000_0005, 12);
    rd_chk("reverse status", `REG_STAT, 32'h0000_000A);
    done("reverse ticks");
    wr(`REG_CMD, 32'h0000_0001);
    expect_enc(32'h0000_0000, 12);
    `CHK("target clears", 1, clr_cnt)
    wr(`REG_CTRL, 32'h0000_0010);
    steps(1'b0, 2);
    trig_en <= 1'b1;
    repeat (40) @(posedge clk);
    trig_en <= 1'b0;
    repeat (40) @(posedge clk);
    expect_enc(32'h0000_0000, 14);
    `CHK("target clears", 2, clr_cnt)
    done("clear");
    wr(`REG_CTRL, 32'h0000_0000);
    wr(`REG_DEB0 + 4'h1, 32'h0000_0001);
    wr(`REG_DEB0 + 4'h2, 32'h0000_0001);
    m0 = tick_cnt;
    steps(1'b0, 1);
    expect_enc(32'h0000_0000, m0);
    repeat (300) @(posedge clk);
    expect_enc(32'h0000_0001, m0 + 1);
    done("debounce");
    trig_en <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(`REG_MULT, i ? 32'h0000_0003 : 32'h0000_0002);
      wr(`REG_DIV, i ? 32'h0000_0002 : 32'h0000_0001);
      repeat (256) @(posedge clk);
      m0 = mult_cnt;
      repeat (512) @(posedge clk);
      m0 = mult_cnt - m0;
      `CHK("pulse rate", 1'b1, (m0 >= (i ? 11 : 15)) && (m0 <= (i ? 13 : 17)))
    end
    trig_en <= 1'b0;
    wr(`REG_MULT, 32'h0000_0000);
    rd_chk("mult clamp", `REG_MULT, 32'h0000_0001);
    wr(`REG_DEB0 + 4'h1, 32'h0000_0000);
    wr(`REG_DEB0 + 4'h2, 32'h0000_0000);
    wr(`REG_MULT, 32'h0000_0002);
    wr(`REG_DIV, 32'h0000_0001);
    wr(`REG_CTRL, 32'h0000_00C0);
    steps(1'b0, 8);
    m0 = mult_cnt;
    steps(1'b0, 8);
    m0 = mult_cnt - m0;
    `CHK("tick source rate", 1'b1, (m0 >= 15) && (m0 <= 17))
    done("multiplier");
    wr(`REG_CTRL, 32'h0000_000A);
    repeat (2) @(posedge clk);
    `CHK("port0 oe", 1'b1, p0_oe)
    `CHK("port0 level", 1'b1, p0_out)
    wr(`REG_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK("port0 input", 1'b0, p0_oe)
    `CHK("port0 term", 1'b1, p0_term)
    done("bidirectional port");
    final_report();
  end
endmodule // encoder_tick_and_rate_multiplier_tb_top
`default_nettype wire
